// file: logic/obcr_pkg.sv
// obcr_pkg: field positions, encodings and cycle counts for the clock/reset option byte decoder
// assumes: the option byte is presented as an 8-bit static value from the nonvolatile array
package obcr_pkg;

  // option byte 1 field positions
  localparam int unsigned POS_PACKAGE_SELECT = 7;
  localparam int unsigned POS_RESET_CYCLE    = 6;
  localparam int unsigned POS_CLK_TYPE_HI    = 5;
  localparam int unsigned POS_CLK_TYPE_LO    = 4;
  localparam int unsigned POS_RANGE_HI       = 3;
  localparam int unsigned POS_RANGE_LO       = 1;
  localparam int unsigned POS_PLL_OFF        = 0;

  // erased-array content, used until the byte is captured
  localparam logic [7:0] OPT_RESET_VALUE = 8'hff;

  // reset phase lengths in cpu cycles
  localparam logic [12:0] RESET_CYCLES_LONG  = 13'h1000;
  localparam logic [12:0] RESET_CYCLES_SHORT = 13'h0100;

  // pads per io port and number of io ports
  localparam int unsigned PADS_PER_PORT = 8;
  localparam int unsigned NUM_PORTS     = 4;

  // clock source type encodings
  typedef enum logic [1:0] {
    OBCR_SRC_RESONATOR = 2'h0,
    OBCR_SRC_RESERVED  = 2'h1,
    OBCR_SRC_INT_RC    = 2'h2,
    OBCR_SRC_EXTERNAL  = 2'h3
  } obcr_src_e;

  // oscillator range encodings
  localparam logic [2:0] RANGE_LOW_POWER    = 3'h0;
  localparam logic [2:0] RANGE_MEDIUM_POWER = 3'h1;
  localparam logic [2:0] RANGE_MEDIUM_SPEED = 3'h2;
  localparam logic [2:0] RANGE_HIGH_SPEED   = 3'h3;

endpackage : obcr_pkg

// file: logic/obcr_cfg_if.sv
// obcr_cfg_if: decoded option fields passed from the capture stage to the delay counter
// assumes: single clk_sys domain
`timescale 1ns/1ps
interface obcr_cfg_if;
  logic       captured;      // option byte has been latched
  logic       short_reset;   // 256-cycle delay selected
  logic       start;         // one-cycle start of a delay
  logic       busy;          // delay in progress
  logic       done;          // one-cycle end of a delay

  modport ctrl (output captured, output short_reset, output start, input busy, input done);
  modport cnt  (input captured, input short_reset, input start, output busy, output done);
endinterface : obcr_cfg_if

// file: logic/obcr_delay.sv
// obcr_delay: reset-phase / halt-exit delay counter
// assumes: started only after the option byte is captured
`timescale 1ns/1ps
module obcr_delay (
  input wire logic clk_sys,    // system clock
  input wire logic nrst,       // async reset, active low
  obcr_cfg_if.cnt  cfg         // configuration and control
);
  import obcr_pkg::*;

  logic [12:0] cnt_q;
  logic        busy_q;
  logic        done_q;

  // load length minus one on start, count down to zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= 13'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cfg.start && cfg.captured) begin
        cnt_q  <= cfg.short_reset ? RESET_CYCLES_SHORT - 13'h0001 : RESET_CYCLES_LONG - 13'h0001;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 13'h0000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 13'h0001;
        end
      end
    end
  end

  assign cfg.busy = busy_q;
  assign cfg.done = done_q;
endmodule : obcr_delay

// file: logic/obcr_top.sv
// obcr_top: decoder of the static clock/reset option byte
// assumes: opt_byte is static from the nonvolatile array, sampled through a synchroniser
`timescale 1ns/1ps
module obcr_top (
  input  wire logic                    clk_sys,             // system clock, 10 MHz
  input  wire logic                    nrst,                // async reset, active low
  input  wire logic [7:0]              opt_byte,            // static option byte 1
  input  wire logic                    halt_exit_req,       // pulse: start halt-exit delay
  output logic                         package_select,      // 1 large package, 0 small
  output logic [obcr_pkg::NUM_PORTS-1:0][obcr_pkg::PADS_PER_PORT-1:0] pad_bonded, // pad bonded map
  output logic [obcr_pkg::NUM_PORTS-1:0][obcr_pkg::PADS_PER_PORT-1:0] pad_pullup, // reset pull-up enables
  output logic                         reset_cycle_select,  // 1 short delay
  output obcr_pkg::obcr_src_e          clock_source_type,   // main clock source
  output logic [2:0]                   oscillator_range,    // range field
  output logic [3:0]                   osc_current_sel,     // one-hot resonator current
  output logic                         osc_resonator_en,    // resonator drive enabled
  output logic                         osc_int_rc_en,       // internal rc enabled
  output logic                         osc_bypass,          // external clock bypass
  output logic                         pll_en,              // times-two pll enabled
  output logic                         cfg_warning,         // illegal or advised-against setting
  output logic                         cpu_reset_n,         // cpu held in reset while low
  output logic                         delay_busy           // reset or halt-exit delay running
);
  import obcr_pkg::*;

  obcr_cfg_if cfg ();

  logic [7:0] s1_q, s2_q, s3_q;
  logic [2:0] fill_q;           // stages already holding sampled data
  logic [7:0] opt_q;
  logic       cap_q;
  logic       boot_q;
  logic       run_q;

  // three-stage synchroniser on the static byte
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= OPT_RESET_VALUE;
      s2_q <= OPT_RESET_VALUE;
      s3_q <= OPT_RESET_VALUE;
      fill_q <= 3'h0;
    end else begin
      fill_q <= {fill_q[1:0], 1'b1};
      s1_q <= opt_byte;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // capture once, after the last two stages agree, then hold
  // the reset fill of the stages must never be taken for the byte
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      opt_q <= OPT_RESET_VALUE;
      cap_q <= 1'b0;
    end else if (!cap_q && fill_q[2] && (s2_q == s3_q)) begin
      opt_q <= s3_q;
      cap_q <= 1'b1;
    end
  end

  // reset-phase sequencing: boot delay, then run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      boot_q <= 1'b0;
      run_q  <= 1'b0;
    end else begin
      if (cap_q && !boot_q) begin
        boot_q <= 1'b1;
      end
      if (cfg.done) begin
        run_q <= 1'b1;
      end
    end
  end

  assign cfg.captured    = cap_q;
  assign cfg.short_reset = opt_q[POS_RESET_CYCLE];
  assign cfg.start       = (cap_q && !boot_q) || (run_q && halt_exit_req && !cfg.busy);

  obcr_delay u_delay (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .cfg     (cfg.cnt)
  );

  // field decode from the held byte
  assign package_select     = opt_q[POS_PACKAGE_SELECT];
  assign reset_cycle_select = opt_q[POS_RESET_CYCLE];
  assign clock_source_type  = obcr_src_e'(opt_q[POS_CLK_TYPE_HI:POS_CLK_TYPE_LO]);
  assign oscillator_range   = opt_q[POS_RANGE_HI:POS_RANGE_LO];
  assign pll_en             = cap_q && !opt_q[POS_PLL_OFF];

  // clock source enables
  always_comb begin
    osc_resonator_en = 1'b0;
    osc_int_rc_en    = 1'b0;
    osc_bypass       = 1'b0;
    unique case (clock_source_type)
      OBCR_SRC_RESONATOR: osc_resonator_en = 1'b1;
      OBCR_SRC_INT_RC:    osc_int_rc_en    = 1'b1;
      OBCR_SRC_EXTERNAL:  osc_bypass       = 1'b1;
      OBCR_SRC_RESERVED:  osc_int_rc_en    = 1'b1; // reserved falls back to rc
    endcase
  end

  // resonator current source, only when resonator selected
  always_comb begin
    osc_current_sel = 4'h0;
    if (osc_resonator_en) begin
      unique case (oscillator_range)
        RANGE_LOW_POWER:    osc_current_sel = 4'h1;
        RANGE_MEDIUM_POWER: osc_current_sel = 4'h2;
        RANGE_MEDIUM_SPEED: osc_current_sel = 4'h4;
        RANGE_HIGH_SPEED:   osc_current_sel = 4'h8;
        default:            osc_current_sel = 4'h8;
      endcase
    end
  end

  // flags settings the configuring party should avoid
  assign cfg_warning = cap_q && (
      (pll_en && clock_source_type == OBCR_SRC_INT_RC)
    || (pll_en && oscillator_range != RANGE_MEDIUM_POWER)
    || (osc_resonator_en && reset_cycle_select)
    || (clock_source_type == OBCR_SRC_RESERVED));

  // pads: bonded map by package, unbonded pull up after reset
  genvar gp, gb;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      for (gb = 0; gb < PADS_PER_PORT; gb++) begin : g_pad
        // small package drops upper half of the last port
        assign pad_bonded[gp][gb] = package_select || !(gp == NUM_PORTS-1 && gb >= PADS_PER_PORT/2);
        assign pad_pullup[gp][gb] = !pad_bonded[gp][gb] || !run_q;
      end
    end
  endgenerate

  assign cpu_reset_n = run_q;
  assign delay_busy  = cfg.busy;
endmodule : obcr_top

// file: dv/obcr_checker.sv
// obcr_checker: port assertions for obcr_top
// assumes: opt_byte only changes while nrst is low
`timescale 1ns/1ps
module obcr_checker (
  input wire logic                                                        clk_sys,            // clock
  input wire logic                                                        nrst,               // reset, active low
  input wire logic [7:0]                                                  opt_byte,           // option byte
  input wire logic                                                        package_select,     // package
  input wire logic [obcr_pkg::NUM_PORTS-1:0][obcr_pkg::PADS_PER_PORT-1:0] pad_bonded,         // bonded map
  input wire logic [obcr_pkg::NUM_PORTS-1:0][obcr_pkg::PADS_PER_PORT-1:0] pad_pullup,         // pull-ups
  input wire logic                                                        reset_cycle_select, // short delay
  input wire obcr_pkg::obcr_src_e                                         clock_source_type,  // source
  input wire logic [2:0]                                                  oscillator_range,   // range
  input wire logic [3:0]                                                  osc_current_sel,    // current
  input wire logic                                                        osc_bypass,         // bypass
  input wire logic                                                        osc_int_rc_en,      // rc on
  input wire logic                                                        osc_resonator_en,   // resonator on
  input wire logic                                                        pll_en,             // pll on
  input wire logic                                                        cfg_warning,        // warning
  input wire logic                                                        cpu_reset_n,        // cpu run
  input wire logic                                                        delay_busy          // delay running
);
  import obcr_pkg::*;

  logic [12:0] busy_cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // cycles spent busy
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) busy_cnt_q <= 13'h0;
    else busy_cnt_q <= delay_busy ? busy_cnt_q + 13'h1 : 13'h0;
  end
  a_pkg_field: assert property (cpu_reset_n |-> package_select == opt_byte[7]) else $error("package bit");
  a_rst_field: assert property (cpu_reset_n |-> reset_cycle_select == opt_byte[6]) else $error("delay bit");
  a_src_field: assert property (cpu_reset_n |-> clock_source_type == opt_byte[5:4]) else $error("source");
  a_range_field: assert property (cpu_reset_n |-> oscillator_range == opt_byte[3:1]) else $error("range");
  a_pll_field: assert property (cpu_reset_n |-> pll_en == !opt_byte[0]) else $error("pll bit");
  a_bonded_map: assert property (pad_bonded == (package_select ? 32'hffffffff : 32'h0fffffff))
    else $error("bonded map");
  a_unbonded_pull: assert property ((pad_pullup | pad_bonded) == 32'hffffffff) else $error("pull-up");
  a_reset_pull: assert property (!cpu_reset_n |-> pad_pullup == 32'hffffffff) else $error("reset pull");
  a_current_sel: assert property (clock_source_type == OBCR_SRC_RESONATOR ? $onehot(osc_current_sel)
    : osc_current_sel == 4'h0) else $error("current select");
  a_bypass_src: assert property (osc_bypass == (clock_source_type == OBCR_SRC_EXTERNAL)) else $error("bypass");
  a_delay_len: assert property ($fell(delay_busy)
    |-> busy_cnt_q == (reset_cycle_select ? RESET_CYCLES_SHORT : RESET_CYCLES_LONG)) else $error("delay length");
  a_held_const: assert property (cpu_reset_n |=> $stable({package_select, reset_cycle_select,
    clock_source_type, oscillator_range, pll_en})) else $error("fields moved");
  a_pll_warn: assert property (pll_en && (osc_int_rc_en || oscillator_range != RANGE_MEDIUM_POWER)
    |-> cfg_warning) else $error("pll warning");
  a_res_warn: assert property (osc_resonator_en && reset_cycle_select |-> cfg_warning)
    else $error("resonator warning");
endmodule : obcr_checker
bind obcr_top obcr_checker u_chk (
  .clk_sys            (clk_sys),
  .nrst               (nrst),
  .opt_byte           (opt_byte),
  .package_select     (package_select),
  .pad_bonded         (pad_bonded),
  .pad_pullup         (pad_pullup),
  .reset_cycle_select (reset_cycle_select),
  .clock_source_type  (clock_source_type),
  .oscillator_range   (oscillator_range),
  .osc_current_sel    (osc_current_sel),
  .osc_bypass         (osc_bypass),
  .osc_int_rc_en      (osc_int_rc_en),
  .osc_resonator_en   (osc_resonator_en),
  .pll_en             (pll_en),
  .cfg_warning        (cfg_warning),
  .cpu_reset_n        (cpu_reset_n),
  .delay_busy         (delay_busy)
);

// file: dv/tb.sv
// tb: self-checking bench for obcr_top
// assumes: 10 MHz clk_sys, byte changed only in reset
`timescale 1ns/1ps
module tb;
  import obcr_pkg::*;
  logic clk_sys, nrst, halt_exit_req, package_select, reset_cycle_select, osc_resonator_en;
  logic osc_int_rc_en, osc_bypass, pll_en, cfg_warning, cpu_reset_n, delay_busy;
  logic [7:0] opt_byte, lfsr_q, b;
  logic [NUM_PORTS-1:0][PADS_PER_PORT-1:0] pad_bonded, pad_pullup;
  obcr_src_e clock_source_type;
  logic [2:0] oscillator_range;
  logic [3:0] osc_current_sel;
  int failures, total_checks, n, k;
  obcr_top dut (.clk_sys, .nrst, .opt_byte, .halt_exit_req, .package_select, .pad_bonded, .pad_pullup,
    .reset_cycle_select, .clock_source_type, .oscillator_range, .osc_current_sel, .osc_resonator_en,
    .osc_int_rc_en, .osc_bypass, .pll_en, .cfg_warning, .cpu_reset_n, .delay_busy);
  // expected run-time decode
  function automatic logic [12:0] exp_dec(logic [7:0] v);
    logic [1:0] t;
    t = v[5:4];
    return {1'b1, v[7:1], !v[0], (!v[0] && (t == 2'h2 || v[3:1] != 3'h1)) || (t == 2'h0 && v[6])
      || t == 2'h1, t == 2'h0, t == 2'h1 || t == 2'h2, t == 2'h3};
  endfunction : exp_dec
  // expected one-hot resonator current, highest for the unused range codes
  function automatic logic [3:0] exp_cur(logic [7:0] v);
    if (v[5:4] != 2'h0) return 4'h0;
    return (v[3:1] > RANGE_HIGH_SPEED) ? 4'h8 : 4'h1 << v[3:1];
  endfunction : exp_cur
  // next random value
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // count busy cycles, with a stray request while busy
  task automatic count_busy(output int c);
    c = 0;
    for (k = 0; k < 20 && delay_busy !== 1'b1; k++) @(negedge clk_sys);
    while (delay_busy === 1'b1 && c < 5000) begin
      c++;
      @(posedge clk_sys) halt_exit_req <= (c == 5);
      @(negedge clk_sys);
    end
    if (c == 0 || c >= 5000) begin
      failures++;
      end_of_test();
    end
  endtask : count_busy
  // clock generator
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    halt_exit_req = 1'b0;
    opt_byte = 8'h02;
    lfsr_q = 8'h16;
    failures = 0;
    total_checks = 0;
    for (int i = 0; i < 11; i++) begin
      b = (i == 0) ? 8'h02 : (i == 1) ? 8'h62 : (i == 2) ? 8'hff : (i == 8) ? 8'h40 : (i == 9) ? 8'h45
        : (i == 10) ? 8'h47 : (lfsr_q | 8'h40);
      @(posedge clk_sys);
      nrst <= 1'b0;
      opt_byte <= b;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({package_select, cpu_reset_n, delay_busy, pll_en}, 4'h8);
      chk(pad_pullup, 32'hffffffff);
      @(posedge clk_sys) nrst <= 1'b1;
      count_busy(n);
      chk(n, b[6] ? RESET_CYCLES_SHORT : RESET_CYCLES_LONG);
      for (k = 0; k < 5 && cpu_reset_n !== 1'b1; k++) @(negedge clk_sys);
      chk({cpu_reset_n, package_select, reset_cycle_select, clock_source_type, oscillator_range, pll_en,
        cfg_warning, osc_resonator_en, osc_int_rc_en, osc_bypass}, exp_dec(b));
      chk(pad_bonded, b[7] ? 32'hffffffff : 32'h0fffffff);
      chk(pad_pullup, b[7] ? 32'h0 : 32'hf0000000);
      chk(osc_current_sel, exp_cur(b));
      @(posedge clk_sys) halt_exit_req <= 1'b1;
      count_busy(n);
      chk(n, b[6] ? RESET_CYCLES_SHORT : RESET_CYCLES_LONG);
      lfsr_q = lfsr_next(lfsr_q);
    end
    end_of_test();
  end
endmodule : tb
